// file: core/pidt_regs.svh
// Constants for the page interleave DRAM timing sequencer
//----------------------------------------------------------------
//----------------------------------------------------------------
`ifndef PIDT_REGS_SVH
`define PIDT_REGS_SVH

// Widths
`define PIDT_ADDR_W 24
`define PIDT_BANKS 4
`define PIDT_TAG_W 12
`define PIDT_WAIT_W 5
`define PIDT_PRE_W 4
`define PIDT_CTRL_A_W 8

// Row precharge field of the first timing control byte
`define PIDT_RP_LSB 3
`define PIDT_RP_MSB 5

// Address bit positions for page and bank selection
`define PIDT_PAGE4K_LSB 12
`define PIDT_PAGE8K_LSB 13
`define PIDT_ILV_BANK_LO 11
`define PIDT_ILV_BANK_HI 12
`define PIDT_REGION_256K_LSB 19
`define PIDT_REGION_1M_LSB 21

// Wait state costs
`define PIDT_WAIT_OPEN 5'h01
`define PIDT_WAIT_REOPEN 5'h02
`define PIDT_WAIT_WRITE 5'h01
`define PIDT_WAIT_NONPIPE 5'h01
`define PIDT_WAIT_THIRD 5'h01
`define PIDT_PRE_BASE 4'h1

`endif

// file: core/pidt_pkg.sv
// Types for the page interleave DRAM timing sequencer
`include "pidt_regs.svh"
package pidt_pkg;

	// Interleave arrangement of the banks
	typedef enum logic [1:0] {
		ILV_NONE = 2'b00,
		ILV_TWO = 2'b01,
		ILV_FOUR = 2'b10,
		ILV_THREE = 2'b11
	} pidt_ilv_e;

	// Sequencer states
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_ACC = 1'b1
	} pidt_state_e;

	// One memory request from the local bus
	typedef struct packed {
		logic [`PIDT_ADDR_W-1:0] addr;
		logic write;
		logic a0;
		logic bhe_n;
	} pidt_req_s;

	// Static timing and arrangement settings
	typedef struct packed {
		logic [`PIDT_CTRL_A_W-1:0] dram_timing_ctrl_a;
		logic [1:0] col_pre_ext;
		logic [1:0] col_act_ext;
		pidt_ilv_e ilv;
		logic big_dev;
		logic pipelined;
	} pidt_cfg_s;

	// DRAM strobes, all active low
	typedef struct packed {
		logic [`PIDT_BANKS-1:0] row_strobe_n;
		logic [`PIDT_BANKS-1:0] column_strobe_low_byte_n;
		logic [`PIDT_BANKS-1:0] column_strobe_high_byte_n;
		logic memory_write_strobe_n;
	} pidt_strobe_s;

endpackage

// file: core/pidt_ctrl.sv
// Page interleave DRAM access sequencer
`timescale 1ns/10ps
`include "pidt_regs.svh"
module pidt_ctrl (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input pidt_pkg::pidt_req_s req_data_i,
	input pidt_pkg::pidt_cfg_s cfg_i,
	input wire logic flush_i,
	input wire logic ras_timeout_i,
	output logic idle_o,
	output logic ready_o,
	output pidt_pkg::pidt_strobe_s strobe_o,
	output logic [`PIDT_WAIT_W-1:0] wait_count_o,
	output logic page_hit_o
);
	import pidt_pkg::*;
	// Limitation: one access at a time; the bus side waits for idle_o
	// before the next request, since a request while busy is dropped

	//----------------------------------------------------------------
	// Helper functions
	//----------------------------------------------------------------

	// Bank chosen by an address under the current arrangement
	function automatic logic [1:0] bank_of(
		input logic [`PIDT_ADDR_W-1:0] addr,
		input pidt_ilv_e ilv,
		input logic big
	);
		logic [1:0] region;
		region = big ? addr[`PIDT_REGION_1M_LSB+1:`PIDT_REGION_1M_LSB]
			: addr[`PIDT_REGION_256K_LSB+1:`PIDT_REGION_256K_LSB];
		unique case (ilv)
			// Linear: each bank owns one address region
			ILV_NONE: bank_of = region;
			// Pairs of banks, low bank bit inside the page
			ILV_TWO: bank_of = {region[0], addr[`PIDT_ILV_BANK_LO]};
			// All four banks share one page
			ILV_FOUR: bank_of = addr[`PIDT_ILV_BANK_HI:`PIDT_ILV_BANK_LO];
			// First region interleaved, everything above goes to bank two
			ILV_THREE: bank_of = (region == 2'b00) ? {1'b0, addr[`PIDT_ILV_BANK_LO]} : 2'b10;
		endcase
	endfunction

	// Page identity of an address: 4K pages for small devices, 8K otherwise
	// Four-way uses the wide page so that all banks agree on one tag
	function automatic logic [`PIDT_TAG_W-1:0] tag_of(
		input logic [`PIDT_ADDR_W-1:0] addr,
		input logic wide
	);
		tag_of = wide ? {addr[`PIDT_ADDR_W-1:`PIDT_PAGE8K_LSB], 1'b0}
			: addr[`PIDT_ADDR_W-1:`PIDT_PAGE4K_LSB];
	endfunction

	//----------------------------------------------------------------
	// State
	//----------------------------------------------------------------

	pidt_state_e state; // Sequencer state
	pidt_req_s cur; // Request being served
	logic [1:0] cur_bank; // Bank of the request being served
	logic [`PIDT_BANKS-1:0] cur_mask; // Banks opened by the current access
	logic [`PIDT_TAG_W-1:0] open_row [`PIDT_BANKS]; // Open page per bank
	logic [`PIDT_BANKS-1:0] row_valid; // Open page still usable per bank
	logic [`PIDT_BANKS-1:0] ras_on; // Row strobe driven per bank
	logic [`PIDT_PRE_W-1:0] pre_cnt; // Row precharge cycles left
	logic [`PIDT_WAIT_W-1:0] wcnt; // Wait states left

	//----------------------------------------------------------------
	// Request classification
	//----------------------------------------------------------------

	wire logic take = (state == ST_IDLE) && req_i; // Request accepted this edge
	// Bank and page of the address on the bus this cycle
	wire logic [1:0] new_bank = bank_of(req_data_i.addr, cfg_i.ilv, cfg_i.big_dev);
	wire logic wide_page = cfg_i.big_dev || (cfg_i.ilv == ILV_FOUR);
	wire logic [`PIDT_TAG_W-1:0] new_tag = tag_of(req_data_i.addr, wide_page);

	// A flush in the same cycle wins, so the request already sees a miss
	wire logic [`PIDT_BANKS-1:0] valid_eff = (flush_i || ras_timeout_i) ? '0 : row_valid;

	// Page hit needs a valid open row with a matching page
	wire logic hit = valid_eff[new_bank] && (open_row[new_bank] == new_tag);

	// Bank holds another row: it must close and precharge first
	wire logic reopen = valid_eff[new_bank] && !hit;

	// Banks whose row strobe this access opens
	wire logic [`PIDT_BANKS-1:0] new_mask = (cfg_i.ilv == ILV_FOUR) ? 4'hF
		: (4'h1 << new_bank);

	// Row precharge extension from the timing control byte
	wire logic [2:0] rp_ext = cfg_i.dram_timing_ctrl_a[`PIDT_RP_MSB:`PIDT_RP_LSB];

	//----------------------------------------------------------------
	// Wait state budget
	//----------------------------------------------------------------

	// Cost of reaching the page: none, page open, or precharge then open
	wire logic [`PIDT_WAIT_W-1:0] page_waits = hit ? 5'h00
		: reopen ? (`PIDT_WAIT_REOPEN + {2'b00, rp_ext})
		: `PIDT_WAIT_OPEN;

	// Column timing extensions apply to every access
	wire logic [`PIDT_WAIT_W-1:0] col_waits = {3'b000, cfg_i.col_pre_ext}
		+ {3'b000, cfg_i.col_act_ext};

	// A pipelined write repeats the second state for parity generation
	wire logic [`PIDT_WAIT_W-1:0] write_waits = (req_data_i.write && cfg_i.pipelined)
		? `PIDT_WAIT_WRITE : 5'h00;

	// Without pipelined addressing the address arrives one state later
	// Trade-off: one flat wait rather than a separate non-pipelined timing path
	wire logic [`PIDT_WAIT_W-1:0] pipe_waits = cfg_i.pipelined ? 5'h00
		: `PIDT_WAIT_NONPIPE;

	// The bank outside the interleaved pair is one state slower
	wire logic [`PIDT_WAIT_W-1:0] third_waits = ((cfg_i.ilv == ILV_THREE) && (new_bank == 2'b10))
		? `PIDT_WAIT_THIRD : 5'h00;

	// Sum of every cost; the worst case is 17, so five bits never wrap
	wire logic [`PIDT_WAIT_W-1:0] total_waits = page_waits + col_waits + write_waits
		+ pipe_waits + third_waits;

	// Precharge length on a reopen; the base cycle is the extra wait
	wire logic [`PIDT_PRE_W-1:0] pre_load = reopen ? (`PIDT_PRE_BASE + {1'b0, rp_ext}) : 4'h0;

	//----------------------------------------------------------------
	// Strobe decoding
	//----------------------------------------------------------------

	// Columns only move once the row is up and precharge is over
	wire logic col_phase = (state == ST_ACC) && (pre_cnt == 4'h0) && ras_on[cur_bank];
	// One-hot select of the bank being served
	wire logic [`PIDT_BANKS-1:0] bank_hot = 4'h1 << cur_bank;

	// Low byte on even address, high byte when byte-high enable is low
	wire logic [`PIDT_BANKS-1:0] next_cas_lo = (col_phase && !cur.a0) ? bank_hot : 4'h0;
	wire logic [`PIDT_BANKS-1:0] next_cas_hi = (col_phase && !cur.bhe_n) ? bank_hot : 4'h0;
	wire logic next_we = col_phase && cur.write;

	// Handshake back to the bus
	assign ready_o = (state == ST_ACC) && (wcnt == 5'h00);
	assign idle_o = (state == ST_IDLE);

	//----------------------------------------------------------------
	// Sequencer
	//----------------------------------------------------------------

	// Two states are enough: accept, then count waits to the ready cycle
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state <= ST_IDLE;
			cur <= '0;
			cur_bank <= 2'b00;
			cur_mask <= 4'h0;
			wcnt <= 5'h00;
			pre_cnt <= 4'h0;
		end
		else
		begin
			unique case (state)
				// Take a request and load its budget
				ST_IDLE:
				begin
					if (req_i)
					begin
						// Freeze the request so the strobes follow a stable address
						state <= ST_ACC;
						cur <= req_data_i;
						cur_bank <= new_bank;
						cur_mask <= new_mask;
						wcnt <= total_waits;
						pre_cnt <= pre_load;
					end
				end
				// Count down precharge and waits, leave on ready
				ST_ACC:
				begin
					if (pre_cnt != 4'h0)
					begin
						pre_cnt <= pre_cnt - 4'h1;
					end
					// Ready shows while the count reads zero, then the bus is free
					if (wcnt == 5'h00)
					begin
						state <= ST_IDLE;
					end
					else
					begin
						wcnt <= wcnt - 5'h01;
					end
				end
			endcase
		end
	end

	//----------------------------------------------------------------
	// Open page bookkeeping
	//----------------------------------------------------------------

	// Record the page on every miss; hits leave the entry alone
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int b = 0; b < `PIDT_BANKS; b++)
			begin
				open_row[b] <= '0;
			end
		end
		else if (take && !hit)
		begin
			for (int b = 0; b < `PIDT_BANKS; b++)
			begin
				if (new_mask[b])
				begin
					// Four-way writes the same page into all banks at once
					open_row[b] <= new_tag;
				end
			end
		end
	end

	// Valid flags: flush and timeout drop them, a miss sets them again
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			row_valid <= 4'h0;
		end
		else if (take && !hit)
		begin
			// The new page is good even if a flush came with it
			row_valid <= valid_eff | new_mask;
		end
		else
		begin
			// Otherwise only flushes and timeouts change the flags
			row_valid <= valid_eff;
		end
	end

	// Row strobes stay up across hits; a reopen drops them for precharge
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ras_on <= 4'h0;
		end
		else if (flush_i || ras_timeout_i)
		begin
			// Outside cycles own the rows; an access in flight keeps its own
			ras_on <= (state == ST_ACC) ? (cur_mask & ras_on) : 4'h0;
		end
		else if (take && reopen)
		begin
			// Drop the row so precharge can run before it opens again
			ras_on <= ras_on & ~new_mask;
		end
		else if ((state == ST_ACC) && (pre_cnt == 4'h0))
		begin
			// Other open banks keep their strobe: several rows at once
			ras_on <= ras_on | cur_mask;
		end
	end

	//----------------------------------------------------------------
	// Registered outputs
	//----------------------------------------------------------------

	// Strobes leave flip-flops so the pins carry no decode glitches
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			strobe_o <= '1;
		end
		else
		begin
			strobe_o.row_strobe_n <= ~ras_on;
			strobe_o.column_strobe_low_byte_n <= ~next_cas_lo;
			strobe_o.column_strobe_high_byte_n <= ~next_cas_hi;
			strobe_o.memory_write_strobe_n <= ~next_we;
		end
	end

	// Last access summary for observation
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wait_count_o <= 5'h00;
			page_hit_o <= 1'b0;
		end
		else if (take)
		begin
			// Held until the next take so the bus side can read it at leisure
			wait_count_o <= total_waits;
			page_hit_o <= hit;
		end
	end

endmodule

// file: verif/pidt_ctrl_props.sv
// Checker for the page interleave DRAM timing sequencer
`timescale 1ns/10ps
`include "pidt_regs.svh"
module pidt_ctrl_props (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input pidt_pkg::pidt_req_s req_data_i,
	input pidt_pkg::pidt_cfg_s cfg_i,
	input wire logic flush_i,
	input wire logic ras_timeout_i,
	input wire logic idle_o,
	input wire logic ready_o,
	input pidt_pkg::pidt_strobe_s strobe_o,
	input wire logic [`PIDT_WAIT_W-1:0] wait_count_o,
	input wire logic page_hit_o
);
	import pidt_pkg::*;
	wire take = idle_o && req_i; // Request accepted
	// Pipelined read with no column extension and no slow bank
	wire plain = take && cfg_i.pipelined && !req_data_i.write && cfg_i.col_pre_ext == 2'h0
		&& cfg_i.col_act_ext == 2'h0 && cfg_i.ilv != ILV_THREE;
	wire [3:0] col_n = strobe_o.column_strobe_low_byte_n & strobe_o.column_strobe_high_byte_n;
	logic [5:0] since; // Cycles since take, saturating so long waits never wrap
	logic stale; // Pages lost since the last take
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			since <= 6'h00;
			stale <= 1'b1;
		end
		else
		begin
			since <= take ? 6'h01 : since + {5'h00, since != 6'h3F};
			// A take opens its own page, even when a flush comes with it
			stale <= !take && (stale || flush_i || ras_timeout_i);
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	a_ready_one_cycle:
		assert property (ready_o |=> !ready_o && idle_o) else $error("ready held too long");
	a_ready_wait_match:
		assert property (ready_o |-> since == {1'b0, wait_count_o} + 6'h01) else $error("ready off budget");
	a_hit_zero_wait:
		assert property (plain |=> page_hit_o |-> ready_o && wait_count_o == 5'h00) else $error("hit not fast");
	a_write_extra_state:
		assert property (take && cfg_i.pipelined && req_data_i.write |=> !ready_o) else $error("write too short");
	a_miss_cost:
		assert property (plain |=> !page_hit_o |-> wait_count_o == `PIDT_WAIT_OPEN
			|| wait_count_o == `PIDT_WAIT_REOPEN + {2'h0, cfg_i.dram_timing_ctrl_a[`PIDT_RP_MSB:`PIDT_RP_LSB]})
		else $error("miss cost wrong");
	a_flush_miss:
		assert property (take && (stale || flush_i || ras_timeout_i) |=> !page_hit_o) else $error("stale hit");
	a_col_needs_row:
		assert property ((~col_n & strobe_o.row_strobe_n) == 4'h0) else $error("column without row");
	a_write_with_col:
		assert property (!strobe_o.memory_write_strobe_n |-> col_n != 4'hF) else $error("write without column");
endmodule

bind pidt_ctrl pidt_ctrl_props u_props (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i), .req_data_i(req_data_i),
	.cfg_i(cfg_i), .flush_i(flush_i), .ras_timeout_i(ras_timeout_i), .idle_o(idle_o), .ready_o(ready_o),
	.strobe_o(strobe_o), .wait_count_o(wait_count_o), .page_hit_o(page_hit_o));

// file: verif/pidt_dram_model.sv
// Passive model of the fast page mode DRAM banks
`timescale 1ns/10ps
module pidt_dram_model (
	input wire logic mclk_i,
	input pidt_pkg::pidt_strobe_s strobe_i,
	output logic [15:0] col_cycles_o
);
	import pidt_pkg::*;
	// A bank latches a column only while its row is open
	wire [3:0] col_ok = ~(strobe_i.column_strobe_low_byte_n & strobe_i.column_strobe_high_byte_n)
		& ~strobe_i.row_strobe_n;
	logic [15:0] col_count = 16'h0000; // Accepted column cycles so far
	assign col_cycles_o = col_count;
	// Count column cycles that a real device would accept
	always @(posedge mclk_i)
	begin
		col_count <= col_count + {15'h0000, |col_ok};
	end
endmodule

// file: verif/test_pidt_ctrl.sv
// Self-checking bench for the page interleave DRAM timing sequencer
`timescale 1ns/10ps
`include "pidt_regs.svh"
module test_pidt_ctrl;
	import pidt_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req_i = 1'b0;
	pidt_req_s req_data_i = '0;
	pidt_cfg_s cfg_i = '0;
	logic flush_i = 1'b0;
	logic ras_timeout_i = 1'b0;
	logic idle_o;
	logic ready_o;
	logic page_hit_o;
	pidt_strobe_s strobe_o;
	logic [`PIDT_WAIT_W-1:0] wait_count_o;
	logic [15:0] col_cycles;
	int mismatches = 0;
	int check_count = 0;
	always #50 mclk_i = ~mclk_i;
	pidt_ctrl uut (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i), .req_data_i(req_data_i), .cfg_i(cfg_i),
		.flush_i(flush_i), .ras_timeout_i(ras_timeout_i), .idle_o(idle_o), .ready_o(ready_o),
		.strobe_o(strobe_o), .wait_count_o(wait_count_o), .page_hit_o(page_hit_o));
	pidt_dram_model dram (.mclk_i(mclk_i), .strobe_i(strobe_o), .col_cycles_o(col_cycles));
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
			mismatches++;
		end
	endtask
	task close_out;
		$display("Checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One cycle of a side input, inputs always move 2 ns after the edge
	task pulse(input logic tmo);
		flush_i = !tmo;
		ras_timeout_i = tmo;
		@(posedge mclk_i);
		#2;
		flush_i = 1'b0;
		ras_timeout_i = 1'b0;
	endtask
	// New arrangement; flushing keeps old pages from leaking across
	task setup(input logic [2:0] rp, input logic [1:0] pre, act, input pidt_ilv_e ilv, input logic big, pipe);
		cfg_i = '{{2'b00, rp, 3'b000}, pre, act, ilv, big, pipe};
		pulse(1'b0);
	endtask
	// One word access, judged on hit, budget, latency and strobes
	task access(input logic [23:0] a, input logic wr, hit, input logic [4:0] w, input int bank);
		int n;
		req_data_i = '{a, wr, 1'b0, 1'b0};
		req_i = 1'b1;
		check("idle", idle_o, 1);
		@(posedge mclk_i);
		#2;
		req_i = 1'b0;
		check("hit", page_hit_o, hit);
		check("waits", wait_count_o, w);
		n = 1;
		while (ready_o !== 1'b1 && n < 40)
		begin
			@(posedge mclk_i);
			#2;
			n++;
		end
		check("latency", n, 1 + w);
		@(posedge mclk_i);
		#2;
		check("row", strobe_o.row_strobe_n[bank], 0);
		check("write", strobe_o.memory_write_strobe_n, !wr);
		check("col low", strobe_o.column_strobe_low_byte_n[bank], 0);
		check("col high", strobe_o.column_strobe_high_byte_n[bank], 0);
	endtask
	task sc_page;
		setup(3'h3, 2'h0, 2'h0, ILV_NONE, 1'b0, 1'b1);
		access(24'h00_0000, 1'b0, 1'b0, 5'h01, 0);
		access(24'h00_0002, 1'b0, 1'b1, 5'h00, 0);
		access(24'h00_0004, 1'b1, 1'b1, 5'h01, 0);
		access(24'h00_1000, 1'b0, 1'b0, 5'h05, 0);
		access(24'h00_1006, 1'b0, 1'b1, 5'h00, 0);
		access(24'h08_0000, 1'b0, 1'b0, 5'h01, 1);
	endtask
	task sc_flush;
		setup(3'h0, 2'h0, 2'h0, ILV_NONE, 1'b0, 1'b1);
		access(24'h00_0000, 1'b0, 1'b0, 5'h01, 0);
		access(24'h00_1000, 1'b0, 1'b0, 5'h02, 0);
		pulse(1'b0);
		access(24'h00_1000, 1'b0, 1'b0, 5'h01, 0);
		pulse(1'b1);
		access(24'h00_1000, 1'b1, 1'b0, 5'h02, 0);
	endtask
	task sc_ext;
		setup(3'h0, 2'h2, 2'h1, ILV_NONE, 1'b0, 1'b0);
		access(24'h00_0010, 1'b0, 1'b0, 5'h05, 0);
		access(24'h00_0012, 1'b1, 1'b1, 5'h04, 0);
	endtask
	task sc_ilv;
		setup(3'h0, 2'h0, 2'h0, ILV_TWO, 1'b0, 1'b1);
		access(24'h00_0000, 1'b0, 1'b0, 5'h01, 0);
		access(24'h00_0800, 1'b0, 1'b0, 5'h01, 1);
		access(24'h00_0004, 1'b0, 1'b1, 5'h00, 0);
		access(24'h00_0804, 1'b0, 1'b1, 5'h00, 1);
		check("pair rows", strobe_o.row_strobe_n[1:0], 2'b00);
		setup(3'h0, 2'h0, 2'h0, ILV_FOUR, 1'b0, 1'b1);
		access(24'h00_0000, 1'b0, 1'b0, 5'h01, 0);
		access(24'h00_1800, 1'b0, 1'b1, 5'h00, 3);
		check("four rows", strobe_o.row_strobe_n, 4'h0);
		setup(3'h0, 2'h0, 2'h0, ILV_THREE, 1'b0, 1'b1);
		access(24'h08_0000, 1'b0, 1'b0, 5'h02, 2);
		access(24'h08_0002, 1'b0, 1'b1, 5'h01, 2);
		access(24'h00_0800, 1'b0, 1'b0, 5'h01, 1);
		setup(3'h0, 2'h0, 2'h0, ILV_NONE, 1'b1, 1'b1);
		access(24'h00_0000, 1'b0, 1'b0, 5'h01, 0);
		access(24'h00_1000, 1'b0, 1'b1, 5'h00, 0);
	endtask
	// Main sequence
	initial
	begin
		repeat (5) @(posedge mclk_i);
		#2;
		check("reset strobes", strobe_o, pidt_strobe_s'('1));
		check("reset idle", idle_o, 1);
		check("reset ready", ready_o, 0);
		check("reset waits", wait_count_o, 0);
		check("reset hit", page_hit_o, 0);
		rst_i = 1'b0;
		sc_page();
		sc_flush();
		sc_ext();
		sc_ilv();
		check("dram columns", col_cycles != 16'h0000, 1);
		close_out();
	end
	// Watchdog at 20000 cycles, far beyond the hundred or so cycles the tests need
	initial
	begin
		#2000000;
		mismatches++;
		close_out();
	end
endmodule
